// [rtl/wp_logic.sv]
// Write-protection core of an SPI serial memory
`timescale 1ns/1ps
//
// Function
// - Status write instruction updates only protect bits and hardware-protect enable.
// - Array split into four equal segments; none, one, two or four protectable.
// - Protect code 00 none, 01 upper quarter, 10 upper half, 11 all.
// - Protected ranges scale with density and end at the top address.
// - Hardware protection active only with pin low and enable bit set.
// - Hardware protection blocks only nonvolatile status bits, not the array.
// - Write latch cleared at reset so nothing writes until set again.
// - Latch cleared after an array write or status write completes.
// - Write starts only on select rising after whole bytes; else abandoned.
// - During internal write, array accesses are ignored, programming continues.
// - After reset: standby, select inactive, serial output not driven.
// - Active state entered only on a select falling edge after reset.
// - Latch zero: nothing writable; one: unprotected array and unlocked status.
// - Protect bits at status 3:2, enable at bit 7, written by status write.
// - Code 06h sets latch, 04h clears it, whatever the protection.
// - Status write code 01h, received MSB first on rising serial clock.
module wp_logic #(
    parameter int ADDR_W       = 15,
    parameter int WRITE_CYCLES = wp_pkg::WRITE_CYCLES
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    // Serial pins
    input  wire logic              cs_n,
    input  wire logic              sck,
    input  wire logic              si,
    input  wire logic              wp_n,
    output wire logic              so_out,
    output wire logic              so_oe,
    // Status and array write request
    output logic      [7:0]        status,
    output logic                   array_wr,
    output logic      [ADDR_W-1:0] array_addr,
    output logic      [7:0]        array_data
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ACT  = 3'b010,
        ST_BUSY = 3'b100
    } state_t;

    state_t      state;
    logic [2:0]  cs_s;
    logic [2:0]  sck_s;
    logic [1:0]  si_s;
    logic [1:0]  wp_s;
    logic [31:0] bitcnt;
    logic [7:0]  instr;
    logic [ADDR_W-1:0] addr;
    logic [7:0]  shreg;
    logic        latch;
    logic [1:0]  bp;
    logic        hwp_en;
    logic        pend_sr;
    logic        pend_arr;
    logic [31:0] timer;

    // Synchronisers; only stages 1 and later are read
    always_ff @(posedge clk_sys)
    begin
        cs_s  <= {cs_s[1:0], cs_n};
        sck_s <= {sck_s[1:0], sck};
        si_s  <= {si_s[0], si};
        wp_s  <= {wp_s[0], wp_n};
    end

    wire logic cs_fall  = cs_s[2] && !cs_s[1];
    wire logic cs_rise  = !cs_s[2] && cs_s[1];
    wire logic sck_rise = !sck_s[2] && sck_s[1] && !cs_s[1];
    wire logic [7:0] next_shreg = {shreg[6:0], si_s[1]};
    wire logic [1:0] next_bp = {shreg[wp_pkg::SR_BP_HI_POS], shreg[wp_pkg::SR_BP_LO_POS]};
    wire logic [31:0] next_bitcnt = bitcnt + 32'h1;
    wire logic byte_done = sck_rise && (next_bitcnt[2:0] == 3'h0);
    wire logic hw_active = !wp_s[1] && hwp_en;
    wire logic sr_writable = latch && !hw_active;
    wire logic addr_locked;
    wire logic busy = (state == ST_BUSY);
    wire logic instr_byte = byte_done && next_bitcnt == wp_pkg::INSTR_BITS;
    wire logic sr_byte = byte_done && instr == wp_pkg::INSTR_STATUS_WRITE
                      && next_bitcnt == wp_pkg::INSTR_BITS + wp_pkg::DATA_BITS;
    wire logic addr_done = byte_done && instr == wp_pkg::INSTR_ARRAY_WRITE
                      && next_bitcnt == wp_pkg::INSTR_BITS + wp_pkg::ADDR_BITS;
    wire logic data_byte = byte_done && instr == wp_pkg::INSTR_ARRAY_WRITE
                      && next_bitcnt > wp_pkg::INSTR_BITS + wp_pkg::ADDR_BITS;
    wire logic arr_go = cs_rise && pend_arr && state == ST_ACT
                      && bitcnt[2:0] == 3'h0;
    // Pin is checked again at the commit edge, not only at the data byte
    wire logic sr_go = cs_rise && pend_sr && !hw_active && state == ST_ACT
                      && bitcnt == wp_pkg::INSTR_BITS + wp_pkg::DATA_BITS;

    wp_range_check #(.ADDR_W(ADDR_W)) u_range (
        .bp     (bp),
        .addr   (addr),
        .locked (addr_locked)
    );

    // Serial output is never driven here; reads are outside this block
    assign so_out = 1'b0;
    assign so_oe  = 1'b0;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state    <= ST_IDLE;
            bitcnt   <= '0;
            instr    <= '0;
            addr     <= '0;
            shreg    <= '0;
            latch    <= 1'b0;
            bp       <= wp_pkg::BP_NONE;
            hwp_en   <= 1'b0;
            pend_sr  <= 1'b0;
            pend_arr <= 1'b0;
            timer    <= '0;
            array_wr <= 1'b0;
            array_addr <= '0;
            array_data <= '0;
        end
        else
        begin
            array_wr <= 1'b0;
            case (state)
                ST_IDLE:
                    if (cs_fall)
                    begin
                        state  <= ST_ACT;
                        bitcnt <= '0;
                    end
                ST_ACT:
                begin
                    if (cs_fall)
                    begin
                        bitcnt   <= '0;
                        pend_sr  <= 1'b0;
                        pend_arr <= 1'b0;
                    end
                    else if (sck_rise)
                    begin
                        shreg  <= next_shreg;
                        bitcnt <= next_bitcnt;
                    end
                    if (instr_byte)
                        instr <= next_shreg;
                    if (addr_done)
                        addr <= {addr[ADDR_W-9:0], next_shreg};
                    if (instr_byte && next_shreg == wp_pkg::INSTR_ARRAY_WRITE)
                        addr <= '0;
                    if (byte_done && instr == wp_pkg::INSTR_ARRAY_WRITE
                        && next_bitcnt == wp_pkg::INSTR_BITS * 2)
                        addr <= {addr[ADDR_W-9:0], next_shreg};
                    if (sr_byte && sr_writable)
                        pend_sr <= 1'b1;
                    if (data_byte && latch && !addr_locked)
                    begin
                        pend_arr   <= 1'b1;
                        array_data <= next_shreg;
                    end
                    if (cs_rise && bitcnt == wp_pkg::INSTR_BITS)
                    begin
                        if (instr == wp_pkg::INSTR_LATCH_SET)
                            latch <= 1'b1;
                        if (instr == wp_pkg::INSTR_LATCH_CLEAR)
                            latch <= 1'b0;
                    end
                    if (sr_go)
                    begin
                        bp     <= next_bp;
                        hwp_en <= shreg[wp_pkg::SR_HWP_POS];
                    end
                    if (arr_go)
                    begin
                        array_wr   <= 1'b1;
                        array_addr <= addr;
                    end
                    if (sr_go || arr_go)
                    begin
                        state <= ST_BUSY;
                        timer <= '0;
                    end
                    else if (cs_rise)
                        state <= ST_IDLE;
                    if (cs_rise)
                    begin
                        pend_sr  <= 1'b0;
                        pend_arr <= 1'b0;
                    end
                end
                ST_BUSY:
                begin
                    // Frames during programming are ignored; timer runs on
                    timer <= timer + 32'h1;
                    if (timer == WRITE_CYCLES - 1)
                    begin
                        state <= ST_IDLE;
                        latch <= 1'b0;
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    always_comb
    begin
        status = 8'h00;
        status[wp_pkg::SR_BUSY_POS]  = busy;
        status[wp_pkg::SR_LATCH_POS] = latch;
        status[wp_pkg::SR_BP_LO_POS] = bp[0];
        status[wp_pkg::SR_BP_HI_POS] = bp[1];
        status[wp_pkg::SR_HWP_POS]   = hwp_en;
    end

    // Assertions
    property p_latch_reset;
        @(posedge clk_sys) sys_rst |=> !latch;
    endproperty
    a_latch_reset: assert property (p_latch_reset) else $error("latch not cleared");

    property p_busy_done;
        @(posedge clk_sys) disable iff (sys_rst)
        (busy && timer == WRITE_CYCLES - 1) |=> (!latch && !busy);
    endproperty
    a_busy_done: assert property (p_busy_done) else $error("latch kept after write");

    property p_hw_blocks;
        @(posedge clk_sys) disable iff (sys_rst)
        (hw_active && !busy) |=> $stable(bp) && $stable(hwp_en);
    endproperty
    a_hw_blocks: assert property (p_hw_blocks) else $error("protect bits changed");

    property p_no_latch_write;
        @(posedge clk_sys) disable iff (sys_rst) !latch |=> !array_wr;
    endproperty
    a_no_latch_write: assert property (p_no_latch_write)
        else $error("write without latch");

    property p_write_busy;
        @(posedge clk_sys) disable iff (sys_rst) array_wr |-> busy;
    endproperty
    a_write_busy: assert property (p_write_busy) else $error("write not busy");

    property p_locked;
        @(posedge clk_sys) disable iff (sys_rst)
        array_wr |-> !($past(bp) == wp_pkg::BP_ALL);
    endproperty
    a_locked: assert property (p_locked) else $error("locked write");

    property p_idle_wake;
        @(posedge clk_sys) disable iff (sys_rst)
        (state == ST_IDLE && !cs_fall) |=> state != ST_ACT;
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("active without select edge");

    property p_so_off;
        @(posedge clk_sys) !so_oe;
    endproperty
    a_so_off: assert property (p_so_off) else $error("output driven");

    property p_busy_hold;
        @(posedge clk_sys) disable iff (sys_rst)
        (busy && timer < WRITE_CYCLES - 1) |=> busy;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("write cut short");

    sequence s_set_frame;
        cs_rise && state == ST_ACT && bitcnt == wp_pkg::INSTR_BITS
        && instr == wp_pkg::INSTR_LATCH_SET;
    endsequence

    property p_latch_set;
        @(posedge clk_sys) disable iff (sys_rst) s_set_frame |=> latch;
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("latch not set");

    sequence s_unlatched_end;
        cs_rise && state == ST_ACT && !latch;
    endsequence

    property p_sr_unlatched;
        @(posedge clk_sys) disable iff (sys_rst)
        s_unlatched_end |=> $stable(bp) && $stable(hwp_en);
    endproperty
    a_sr_unlatched: assert property (p_sr_unlatched) else $error("status changed");
endmodule

// [rtl/wp_pkg.sv]
// Constants for the serial memory write-protection logic
package wp_pkg;
    localparam logic [7:0] INSTR_STATUS_WRITE = 8'h01;
    localparam logic [7:0] INSTR_ARRAY_WRITE  = 8'h02;
    localparam logic [7:0] INSTR_LATCH_CLEAR  = 8'h04;
    localparam logic [7:0] INSTR_LATCH_SET    = 8'h06;
    localparam int SR_BUSY_POS  = 0;
    localparam int SR_LATCH_POS = 1;
    localparam int SR_BP_LO_POS = 2;
    localparam int SR_BP_HI_POS = 3;
    localparam int SR_HWP_POS   = 7;
    localparam logic [1:0] BP_NONE    = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF    = 2'h2;
    localparam logic [1:0] BP_ALL     = 2'h3;
    localparam int INSTR_BITS = 8;
    localparam int ADDR_BITS  = 16;
    localparam int DATA_BITS  = 8;
    // Self-timed write time and cycle count at 40 MHz
    localparam int WRITE_TIME_US = 6000;
    localparam int CLK_MHZ       = 40;
    localparam int WRITE_CYCLES  = WRITE_TIME_US * CLK_MHZ;
endpackage

// [rtl/wp_range_check.sv]
// Block-protect address decode
`timescale 1ns/1ps
module wp_range_check #(
    parameter int ADDR_W = 15
) (
    // Protection setting and address
    input  wire logic [1:0]        bp,
    input  wire logic [ADDR_W-1:0] addr,
    // Result
    output wire logic              locked
);
    // Top two address bits pick the quarter; ranges always end at the top
    wire logic [1:0] quarter = addr[ADDR_W-1 -: 2];
    assign locked = (bp == wp_pkg::BP_ALL)
                 || (bp == wp_pkg::BP_HALF && quarter[1])
                 || (bp == wp_pkg::BP_QUARTER && quarter == 2'h3);
endmodule

// [testbench/spi_host.sv]
// Host serial controller model: select, serial clock and data
`timescale 1ns/1ps
module spi_host (
    // Pacing clock
    input  wire logic clk_sys,
    // Serial pins
    output logic      cs_n,
    output logic      sck,
    output logic      si
);
    initial
    begin
        cs_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b0;
    end
    // Clock stands low between frames; data toggles so no stale bit looks valid
    task automatic frame(input logic [39:0] v, input int n);
        cs_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        for (int i = 0; i < n; i++)
        begin
            si = v[39-i];
            repeat (4) @(negedge clk_sys);
            sck = 1'b1;
            repeat (4) @(negedge clk_sys);
            sck = 1'b0;
        end
        repeat (4) @(negedge clk_sys);
        cs_n = 1'b1;
        repeat (8) @(negedge clk_sys) si = ~si;
    endtask
endmodule

// [testbench/tb.sv]
// Self-checking bench for the write-protection core
`timescale 1ns/1ps
module tb;
    logic              clk_sys;
    logic              sys_rst;
    logic              wp_n;
    wire logic         cs_n;
    wire logic         sck;
    wire logic         si;
    wire logic         so_out;
    wire logic         so_oe;
    logic       [7:0]  status;
    logic              array_wr;
    logic       [14:0] array_addr;
    logic       [7:0]  array_data;
    logic       [14:0] last_a;
    logic       [7:0]  last_d;
    int                failures;
    int                checks_done;
    int                wr_count;
    int                cycles;
    localparam int     CYCLE_LIMIT = 60000;
    spi_host host (.clk_sys(clk_sys), .cs_n(cs_n), .sck(sck), .si(si));
    wp_logic #(.ADDR_W(15), .WRITE_CYCLES(400)) dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .cs_n(cs_n), .sck(sck), .si(si),
        .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe), .status(status),
        .array_wr(array_wr), .array_addr(array_addr), .array_data(array_data));
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // Sampled mid-cycle so the one-cycle write pulse is settled
    always @(negedge clk_sys)
    begin
        cycles++;
        if (array_wr === 1'b1)
        begin
            wr_count++;
            last_a = array_addr;
            last_d = array_data;
        end
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmd(input logic [7:0] c);
        host.frame({c, 32'h0}, 8);
    endtask
    task automatic srw(input logic [7:0] d);
        host.frame({wp_pkg::INSTR_STATUS_WRITE, d, 24'h0}, 16);
    endtask
    task automatic arw(input logic [15:0] a, input logic [7:0] d);
        host.frame({wp_pkg::INSTR_ARRAY_WRITE, a, d, 8'h0}, 32);
    endtask
    // Busy may never rise on a refused write, so the wait is bounded
    task automatic idle();
        for (int i = 0; i < 600 && status[0] !== 1'b0; i++) @(negedge clk_sys);
        chk("busy", 16'h0, status[0]);
        repeat (4) @(negedge clk_sys);
    endtask
    task automatic t_latch();
        cmd(wp_pkg::INSTR_LATCH_SET);
        chk("latch set", 16'h1, status[1]);
        sys_rst = 1'b1;
        repeat (4) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk("latch after reset", 16'h0, status[1]);
        cmd(wp_pkg::INSTR_LATCH_SET);
        cmd(wp_pkg::INSTR_LATCH_CLEAR);
        chk("latch clear", 16'h0, status[1]);
        $display("test latch done");
    endtask
    task automatic t_no_latch();
        int n0;
        n0 = wr_count;
        srw(8'h8C);
        idle();
        chk("status", 16'h00, status);
        arw(16'h0000, 8'h11);
        idle();
        chk("writes", 16'h0, 16'(wr_count - n0));
        $display("test no_latch done");
    endtask
    task automatic t_status();
        cmd(wp_pkg::INSTR_LATCH_SET);
        srw(8'hFF);
        chk("busy", 16'h1, status[0]);
        idle();
        chk("status", 16'h8C, status);
        $display("test status done");
    endtask
    task automatic t_hwp();
        wp_n = 1'b1;
        cmd(wp_pkg::INSTR_LATCH_SET);
        srw(8'h80);
        idle();
        chk("status", 16'h80, status);
        wp_n = 1'b0;
        cmd(wp_pkg::INSTR_LATCH_SET);
        srw(8'h0C);
        idle();
        chk("status locked", 16'h80, status & 8'h8D);
        cmd(wp_pkg::INSTR_LATCH_SET);
        arw(16'h0100, 8'hC3);
        idle();
        chk("array addr", 16'h0100, last_a);
        wp_n = 1'b1;
        cmd(wp_pkg::INSTR_LATCH_SET);
        srw(8'h00);
        idle();
        chk("status", 16'h00, status);
        $display("test hwp done");
    endtask
    task automatic t_busy();
        int n0;
        n0 = wr_count;
        cmd(wp_pkg::INSTR_LATCH_SET);
        // Two-byte page; the last byte is the one committed
        host.frame({wp_pkg::INSTR_ARRAY_WRITE, 16'h0010, 8'h5A, 8'hAA}, 40);
        arw(16'h0020, 8'h55);
        idle();
        chk("writes", 16'h1, 16'(wr_count - n0));
        chk("array addr", 16'h0010, last_a);
        chk("array data", 16'hAA, last_d);
        chk("latch", 16'h0, status[1]);
        $display("test busy done");
    endtask
    task automatic t_protect();
        logic [15:0] at[6] = '{16'h0000, 16'h3FFF, 16'h4000, 16'h5FFF, 16'h6000, 16'h7FFF};
        logic        lk;
        int          n0;
        for (int b = 0; b < 4; b++)
        begin
            cmd(wp_pkg::INSTR_LATCH_SET);
            srw(8'(b << 2));
            idle();
            chk("protect", 16'(b), status[3:2]);
            foreach (at[i])
            begin
                lk = (b == 3) || (b == 2 && at[i] >= 16'h4000) || (b == 1 && at[i] >= 16'h6000);
                n0 = wr_count;
                cmd(wp_pkg::INSTR_LATCH_SET);
                arw(at[i], at[i][7:0] ^ 8'h5A);
                idle();
                chk("writes", 16'(!lk), 16'(wr_count - n0));
                if (!lk) chk("array addr", at[i], last_a);
            end
        end
        $display("test protect done");
    endtask
    task automatic t_abandon();
        cmd(wp_pkg::INSTR_LATCH_SET);
        host.frame({wp_pkg::INSTR_STATUS_WRITE, 32'h0}, 15);
        idle();
        chk("protect", 16'h3, status[3:2]);
        // One bit past a complete data byte must also abandon
        host.frame({wp_pkg::INSTR_STATUS_WRITE, 32'h0}, 17);
        idle();
        chk("protect", 16'h3, status[3:2]);
        chk("latch", 16'h1, status[1]);
        $display("test abandon done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        failures = 0;
        checks_done = 0;
        sys_rst = 1'b1;
        wp_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (6) @(negedge clk_sys);
        fork
            begin
                chk("status", 16'h00, status);
                chk("so enable", 16'h0, so_oe);
                chk("so data", 16'h0, so_out);
                t_latch();
                t_no_latch();
                t_status();
                t_hwp();
                t_busy();
                t_protect();
                t_abandon();
            end
            begin
                wait (cycles >= CYCLE_LIMIT);
                failures++;
                $display("unexpected cycles: expected below %0d seen %0d", CYCLE_LIMIT, cycles);
            end
        join_any
        report_and_stop();
    end
endmodule
